// ---- hdl/external_interrupt_detector.sv ----
`timescale 1ns/100ps
// Summary of operation
// - sense bit 0 edge, 1 level
// - edge bit 0 falling, 1 rising
// - level bit 0 low, 1 high
// - filter bit selects glitch-filtered input
// - capture bit 0 sampled, 1 every clock
// - override register bit 31 enables override
// - override feeds written bits, pads ignored
// - non-maskable line has identical choices
// - enable/disable writes of ones switch lines
// - event sets flag until cleared
// - nine lines including non-maskable one
module external_interrupt_detector
  import ext_irq_pkg::*;
#(
  parameter int unsigned NUM_LINES = NUM_LINES_DEF,
  parameter int unsigned DIV       = SYNC_DIV
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // pads, bit 0 is the non-maskable line
  input  wire logic [NUM_LINES-1:0] external_line_n,
  // requests toward the system interrupt controller
  output logic      [NUM_LINES-1:0] line_request_q,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  localparam int unsigned DIV_W = (DIV > 1) ? $clog2(DIV) : 1;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration and state registers
  logic [NUM_LINES-1:0] sense_q, sense_d;         // sense_type_select
  logic [NUM_LINES-1:0] edge_pol_q, edge_pol_d;   // edge_polarity_select
  logic [NUM_LINES-1:0] lvl_pol_q, lvl_pol_d;     // level_polarity_select
  logic [NUM_LINES-1:0] filt_q, filt_d;           // input_filter_enable
  logic [NUM_LINES-1:0] force_val_q, force_val_d; // override values
  logic                 override_on_q, override_on_d; // override_mode_on
  logic [NUM_LINES-1:0] capture_q, capture_d;     // capture_mode_select
  logic [NUM_LINES-1:0] line_on_q, line_on_d;     // line enable state
  logic [NUM_LINES-1:0] mask_q, mask_d;           // request_mask_state
  logic [NUM_LINES-1:0] flags_q, flags_d;         // event_flags
  logic [NUM_LINES-1:0] req_d;                    // next request outputs
  logic [NUM_LINES-1:0] hit;                      // detector outputs

  // write-side bus state
  logic [ADDR_W-1:0]    waddr_q, waddr_d;         // held write address
  logic                 waddr_ok_q, waddr_ok_d;   // address taken
  logic [DATA_W-1:0]    wdata_q, wdata_d;         // held write data
  logic [3:0]           wstrb_q, wstrb_d;         // held byte strobes
  logic                 wdata_ok_q, wdata_ok_d;   // data taken
  logic                 bvalid_d;
  logic [1:0]           bresp_d;
  logic                 awready_d, wready_d;

  // read-side bus state
  logic                 arready_d, rvalid_d;
  logic [DATA_W-1:0]    rdata_d;
  logic [1:0]           rresp_d;

  // sampling divider
  logic [DIV_W-1:0]     div_q, div_d;             // clocks since last tick
  logic                 tick_q, tick_d;           // one-cycle sampling strobe

  // decode helpers
  logic                 do_write;                 // write commits this cycle
  logic [DATA_W-1:0]    wmask;                    // byte-expanded strobes
  logic [DATA_W-1:0]    wval;                     // strobed write data
  logic [NUM_LINES-1:0] wbits;                    // low bits of strobed data
  logic [NUM_LINES-1:0] wkeep;                    // low bits of byte mask
  logic [NUM_LINES-1:0] clr_bits;                 // event_flag_clear ones
  logic [DATA_W-1:0]    rword;                    // read mux result
  logic                 rhit;                     // read address mapped

  ////////////////////////////////////////////////////////////////////////////////
  // divider: one enable pulse per sampling period
  always_comb begin
    if (div_q == DIV_W'(DIV - 1)) begin
      div_d  = '0;
      tick_d = 1'b1;
    end else begin
      div_d  = div_q + DIV_W'(1);
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // detectors, one per line
  // nine lines by default
  // line 0 uses the same path
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
    line_detector #(
      .FLEN(FILT_LEN)
    ) u_det (
      .clk           (clk),
      .nrst          (nrst),
      .pad_in        (external_line_n[i]),
      .sample_tick   (tick_q),
      .override_on   (override_on_q),
      .override_val  (force_val_q[i]),
      .capture_free  (capture_q[i]),
      .filt_on       (filt_q[i]),
      .sense_is_level(sense_q[i]),
      .edge_rising   (edge_pol_q[i]),
      .level_high    (lvl_pol_q[i]),
      .hit           (hit[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus write channel and register updates
  always_comb begin
    // channels are taken independently, one write in flight
    waddr_d    = waddr_q;
    waddr_ok_d = waddr_ok_q;
    wdata_d    = wdata_q;
    wstrb_d    = wstrb_q;
    wdata_ok_d = wdata_ok_q;
    bvalid_d   = s_axi_bvalid;
    bresp_d    = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      waddr_d    = s_axi_awaddr;
      waddr_ok_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_d    = s_axi_wdata;
      wstrb_d    = s_axi_wstrb;
      wdata_ok_d = 1'b1;
    end
    do_write = waddr_ok_q && wdata_ok_q && !s_axi_bvalid;
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // ready drops once a beat is held, until the response leaves
    awready_d = !waddr_ok_d && !bvalid_d;
    wready_d  = !wdata_ok_d && !bvalid_d;

    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{wstrb_q[b]}};
    end
    wval     = wdata_q & wmask;
    wbits    = wval[NUM_LINES-1:0];
    wkeep    = wmask[NUM_LINES-1:0];
    clr_bits = '0;

    sense_d       = sense_q;
    edge_pol_d    = edge_pol_q;
    lvl_pol_d     = lvl_pol_q;
    filt_d        = filt_q;
    force_val_d   = force_val_q;
    override_on_d = override_on_q;
    capture_d     = capture_q;
    line_on_d     = line_on_q;
    mask_d        = mask_q;

    if (do_write) begin
      waddr_ok_d = 1'b0;
      wdata_ok_d = 1'b0;
      bvalid_d   = 1'b1;
      bresp_d    = RESP_OKAY;
      if (waddr_q == OFS_SENSE) begin
        sense_d = (sense_q & ~wkeep) | wbits;
      end else if (waddr_q == OFS_EDGE_POL) begin
        edge_pol_d = (edge_pol_q & ~wkeep) | wbits;
      end else if (waddr_q == OFS_LEVEL_POL) begin
        lvl_pol_d = (lvl_pol_q & ~wkeep) | wbits;
      end else if (waddr_q == OFS_FILT) begin
        filt_d = (filt_q & ~wkeep) | wbits;
      end else if (waddr_q == OFS_OVERRIDE) begin
        force_val_d = (force_val_q & ~wkeep) | wbits;
        if (wstrb_q[3]) begin
          override_on_d = wdata_q[OVERRIDE_ON_BIT];
        end
      end else if (waddr_q == OFS_CAPTURE) begin
        capture_d = (capture_q & ~wkeep) | wbits;
      end else if (waddr_q == OFS_LINE_SET) begin
        line_on_d = line_on_q | wbits;
      end else if (waddr_q == OFS_LINE_CLR) begin
        line_on_d = line_on_q & ~wbits;
      end else if (waddr_q == OFS_MASK_SET) begin
        mask_d = mask_q | wbits;
      end else if (waddr_q == OFS_MASK_CLR) begin
        mask_d = mask_q & ~wbits;
      end else if (waddr_q == OFS_FLAG_CLR) begin
        clr_bits = wbits;
      end else if (waddr_q == OFS_MASK_STATE || waddr_q == OFS_FLAGS || waddr_q == OFS_LINE_STATE) begin
        // read-only words ignore writes
        bresp_d = RESP_OKAY;
      end else begin
        // unmapped address
        bresp_d = RESP_SLVERR;
      end
    end

    flags_d = (flags_q & ~clr_bits) | (hit & line_on_q);
    req_d   = flags_q & mask_q;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waddr_q        <= '0;
      waddr_ok_q     <= 1'b0;
      wdata_q        <= REG_RST;
      wstrb_q        <= 4'h0;
      wdata_ok_q     <= 1'b0;
      s_axi_awready  <= 1'b0;
      s_axi_wready   <= 1'b0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= RESP_OKAY;
      sense_q        <= REG_RST[NUM_LINES-1:0];
      edge_pol_q     <= REG_RST[NUM_LINES-1:0];
      lvl_pol_q      <= REG_RST[NUM_LINES-1:0];
      filt_q         <= REG_RST[NUM_LINES-1:0];
      force_val_q    <= REG_RST[NUM_LINES-1:0];
      override_on_q  <= 1'b0;
      capture_q      <= REG_RST[NUM_LINES-1:0];
      line_on_q      <= REG_RST[NUM_LINES-1:0];
      mask_q         <= REG_RST[NUM_LINES-1:0];
      flags_q        <= REG_RST[NUM_LINES-1:0];
      line_request_q <= '0;
    end else begin
      waddr_q        <= waddr_d;
      waddr_ok_q     <= waddr_ok_d;
      wdata_q        <= wdata_d;
      wstrb_q        <= wstrb_d;
      wdata_ok_q     <= wdata_ok_d;
      s_axi_awready  <= awready_d;
      s_axi_wready   <= wready_d;
      s_axi_bvalid   <= bvalid_d;
      s_axi_bresp    <= bresp_d;
      sense_q        <= sense_d;
      edge_pol_q     <= edge_pol_d;
      lvl_pol_q      <= lvl_pol_d;
      filt_q         <= filt_d;
      force_val_q    <= force_val_d;
      override_on_q  <= override_on_d;
      capture_q      <= capture_d;
      line_on_q      <= line_on_d;
      mask_q         <= mask_d;
      flags_q        <= flags_d;
      line_request_q <= req_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus read channel
  always_comb begin
    rword = '0;
    rhit  = 1'b1;
    if (s_axi_araddr == OFS_SENSE) begin
      rword[NUM_LINES-1:0] = sense_q;
    end else if (s_axi_araddr == OFS_EDGE_POL) begin
      rword[NUM_LINES-1:0] = edge_pol_q;
    end else if (s_axi_araddr == OFS_LEVEL_POL) begin
      rword[NUM_LINES-1:0] = lvl_pol_q;
    end else if (s_axi_araddr == OFS_FILT) begin
      rword[NUM_LINES-1:0] = filt_q;
    end else if (s_axi_araddr == OFS_OVERRIDE) begin
      rword[NUM_LINES-1:0]   = force_val_q;
      rword[OVERRIDE_ON_BIT] = override_on_q;
    end else if (s_axi_araddr == OFS_CAPTURE) begin
      rword[NUM_LINES-1:0] = capture_q;
    end else if (s_axi_araddr == OFS_LINE_STATE) begin
      rword[NUM_LINES-1:0] = line_on_q;
    end else if (s_axi_araddr == OFS_MASK_STATE) begin
      rword[NUM_LINES-1:0] = mask_q;
    end else if (s_axi_araddr == OFS_FLAGS) begin
      rword[NUM_LINES-1:0] = flags_q;
    end else if (s_axi_araddr == OFS_LINE_SET || s_axi_araddr == OFS_LINE_CLR ||
                 s_axi_araddr == OFS_MASK_SET || s_axi_araddr == OFS_MASK_CLR ||
                 s_axi_araddr == OFS_FLAG_CLR) begin
      // write-only words read as zero
      rword = '0;
    end else begin
      rhit = 1'b0;
    end

    rvalid_d  = s_axi_rvalid;
    rdata_d   = s_axi_rdata;
    rresp_d   = s_axi_rresp;
    arready_d = s_axi_arready;
    if (s_axi_arvalid && s_axi_arready) begin
      // address taken: answer next cycle
      rvalid_d  = 1'b1;
      rdata_d   = rword;
      rresp_d   = rhit ? RESP_OKAY : RESP_SLVERR;
      arready_d = 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end else if (!s_axi_rvalid) begin
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= REG_RST;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= arready_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rdata   <= rdata_d;
      s_axi_rresp   <= rresp_d;
    end
  end

endmodule

// ---- include/ext_irq_pkg.sv ----
package ext_irq_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int unsigned NUM_LINES_DEF = 9;          // external lines, the non-maskable one included
  localparam int unsigned ADDR_W        = 12;         // byte address bits decoded
  localparam int unsigned DATA_W        = 32;         // bus data width

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [11:0] OFS_MASK_SET   = 12'h000;   // write 1 sets request mask bit
  localparam logic [11:0] OFS_MASK_CLR   = 12'h004;   // write 1 clears request mask bit
  localparam logic [11:0] OFS_MASK_STATE = 12'h008;   // request_mask_state, read only
  localparam logic [11:0] OFS_FLAGS      = 12'h00C;   // event_flags, read only
  localparam logic [11:0] OFS_FLAG_CLR   = 12'h010;   // event_flag_clear, write only
  localparam logic [11:0] OFS_SENSE      = 12'h014;   // sense_type_select
  localparam logic [11:0] OFS_EDGE_POL   = 12'h018;   // edge_polarity_select
  localparam logic [11:0] OFS_LEVEL_POL  = 12'h01C;   // level_polarity_select
  localparam logic [11:0] OFS_FILT       = 12'h020;   // input_filter_enable
  localparam logic [11:0] OFS_OVERRIDE   = 12'h024;   // pad_override_control
  localparam logic [11:0] OFS_CAPTURE    = 12'h028;   // capture_mode_select
  localparam logic [11:0] OFS_LINE_SET   = 12'h030;   // line_enable_set, write only
  localparam logic [11:0] OFS_LINE_CLR   = 12'h034;   // line_disable_set, write only
  localparam logic [11:0] OFS_LINE_STATE = 12'h038;   // line enable state, read only

  ////////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int unsigned OVERRIDE_ON_BIT = 31;       // override_mode_on
  localparam logic [31:0] REG_RST         = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // sampling timing
  localparam int unsigned CLK_HZ      = 50_000_000;   // bus clock rate
  localparam int unsigned SYNC_HZ     = 12_500_000;   // synchronization sampling rate
  localparam int unsigned SYNC_DIV    = (CLK_HZ + SYNC_HZ - 1) / SYNC_HZ; // clocks per sample tick
  localparam int unsigned FILT_LEN    = 3;            // equal samples needed by the filter

endpackage

// ---- hdl/line_detector.sv ----
`timescale 1ns/100ps
// one external line: pad synchroniser, override, sampling, filter and detector
module line_detector
  import ext_irq_pkg::*;
#(
  parameter int unsigned FLEN = FILT_LEN
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pad_in,          // raw pad level
  input  wire logic sample_tick,     // slow sampling strobe
  input  wire logic override_on,     // software drives the detector
  input  wire logic override_val,    // value software forces
  input  wire logic capture_free,    // 1: sample every clock
  input  wire logic filt_on,         // glitch filter in use
  input  wire logic sense_is_level,  // 1: level sensing
  input  wire logic edge_rising,     // 1: rising edge
  input  wire logic level_high,      // 1: high level
  output logic      hit              // detection this cycle
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [2:0]      sync_q, sync_d;   // three pad stages
  logic            pin_q, pin_d;     // accepted pad level
  logic [FLEN-1:0] hist_q, hist_d;   // sample history, newest in bit 0
  logic            stable_q, stable_d; // filtered level
  logic            prev_q, prev_d;   // detector input one clock ago
  logic            src;              // pad or forced value
  logic            strobe;           // take a sample now
  logic            det_in;           // value seen by detector

  // next-state logic
  always_comb begin
    sync_d = {sync_q[1:0], pad_in};
    // a change counts only once stages two and three agree
    pin_d  = (sync_q[1] == sync_q[2]) ? sync_q[2] : pin_q;
    src    = override_on ? override_val : pin_q;
    strobe = capture_free | sample_tick;
    hist_d = strobe ? {hist_q[FLEN-2:0], src} : hist_q;
    if (&hist_q) begin
      stable_d = 1'b1;
    end else if (~|hist_q) begin
      stable_d = 1'b0;
    end else begin
      stable_d = stable_q;
    end
    det_in = filt_on ? stable_q : hist_q[0];
    prev_d = det_in;
    if (sense_is_level) begin
      hit = (det_in == level_high);
    end else begin
      hit = (det_in != prev_q) && (det_in == edge_rising);
    end
  end

  // registers only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_q   <= 3'h0;
      pin_q    <= 1'b0;
      hist_q   <= '0;
      stable_q <= 1'b0;
      prev_q   <= 1'b0;
    end else begin
      sync_q   <= sync_d;
      pin_q    <= pin_d;
      hist_q   <= hist_d;
      stable_q <= stable_d;
      prev_q   <= prev_d;
    end
  end

endmodule

// ---- dv/ext_irq_assertions.sv ----
`timescale 1ns/100ps
module ext_irq_assertions
  import ext_irq_pkg::*;
#(
  parameter int unsigned NUM_LINES = NUM_LINES_DEF,
  parameter int unsigned DIV       = SYNC_DIV
) (
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic [NUM_LINES-1:0] external_line_n,
  input wire logic [NUM_LINES-1:0] line_request_q,
  input wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic [DATA_W-1:0]    s_axi_wdata,
  input wire logic [3:0]           s_axi_wstrb,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic [ADDR_W-1:0]    s_axi_araddr,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [DATA_W-1:0]    s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////////////
  // one clock domain, so one default clock and reset
  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);

  // both write beats taken at the same edge
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // one quiet cycle, then the register and the response land at the same edge
  sequence wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence

  AST_WR_LAT: assert property (wr_take |=> wr_answer)
    else $error("write response late or early");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write beats accepted during response");
  AST_BRESP_CODE: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
    else $error("illegal write response code");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted during data");
  AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read returns nonzero data");
  // a request may only fall shortly after a completed write (clear or mask)
  AST_REQ_STICKY: assert property (|($past(line_request_q) & ~line_request_q) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("request fell without software write");
endmodule

bind external_interrupt_detector ext_irq_assertions #(.NUM_LINES(NUM_LINES), .DIV(DIV)) chk_u (
  .clk(clk), .nrst(nrst), .external_line_n(external_line_n), .line_request_q(line_request_q),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ---- dv/ext_pad_model.sv ----
`timescale 1ns/100ps
module ext_pad_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [8:0] pad_cmd,         // level the bench asks for
  output logic      [8:0] external_line_n  // driven pad levels
);
  logic [8:0] pad_d;  // next pad levels
  // pads always driven, no floating state to model
  always_comb begin
    pad_d = pad_cmd;
  end
  // pads lag the command by a clock, like an external driver off our edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      external_line_n <= 9'h000;
    end else begin
      external_line_n <= pad_d;
    end
  end
endmodule

// ---- dv/tb_external_interrupt_detector.sv ----
`timescale 1ns/100ps
module tb_external_interrupt_detector
  import ext_irq_pkg::*;
;
  logic        clk, nrst;                     // clock and reset
  logic [8:0]  pad_cmd, pads, req;            // pad drive and requests
  logic [11:0] awaddr, araddr;                // bus addresses
  logic [31:0] wdata, rdata;                  // bus data
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;                  // response codes
  int          err_total, checks_done;        // verdict counters

  external_interrupt_detector #(.NUM_LINES(9), .DIV(4)) dut_u (
    .clk(clk), .nrst(nrst), .external_line_n(pads), .line_request_q(req),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ext_pad_model pad_u (.clk(clk), .nrst(nrst), .pad_cmd(pad_cmd), .external_line_n(pads));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict();
    if (err_total == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // compare for data words and request vectors
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t data %h expected %h", $time, got, exp);
    end
  endtask
  // compare for response codes
  task automatic cmp2(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t resp %h expected %h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // write: both beats offered together, each dropped when taken, late bready
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awvalid && awready) begin ad = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin wd = 1'b1; wvalid <= 1'b0; end
    end
    while (!bvalid) @(posedge clk);
    bready <= 1'b1;
    @(posedge clk);
    cmp2(bresp, er);
    bready <= 1'b0;
  endtask
  // read: rready raised only after data shows, so the slave must hold it
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rready <= 1'b1;
    @(posedge clk);
    cmp32(rdata, e);
    cmp2(rresp, er);
    rready <= 1'b0;
  endtask
  // let detection settle, then check flags and request lines
  task automatic flags(input logic [8:0] e, input logic [8:0] r);
    repeat (40) @(posedge clk);
    rd(OFS_FLAGS, {23'h0, e}, RESP_OKAY);
    cmp32({23'h0, req}, {23'h0, r});
  endtask
  task automatic clr();
    wr(OFS_FLAG_CLR, 32'h0000_01FF, RESP_OKAY);
  endtask
  // two-cycle pad glitch on all lines
  task automatic pulse();
    @(posedge clk) pad_cmd <= 9'h1FF;
    repeat (2) @(posedge clk);
    pad_cmd <= 9'h000;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; pad_cmd = 9'h000;
    nrst = 1'b0; err_total = 0; checks_done = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++) rd(OFS_SENSE + 12'(4 * i), 32'h0, RESP_OKAY);
    rd(OFS_LINE_SET, 32'h0, RESP_OKAY);
    rd(12'h3FC, 32'h0, RESP_SLVERR);
    wr(12'h02C, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(OFS_OVERRIDE, 32'h8000_0000, RESP_OKAY);
    rd(OFS_OVERRIDE, 32'h8000_0000, RESP_OKAY);
    wr(OFS_CAPTURE, 32'h1FF, RESP_OKAY);
    wr(OFS_LINE_SET, 32'h1FF, RESP_OKAY);
    wr(OFS_MASK_SET, 32'h1FF, RESP_OKAY);
    rd(OFS_LINE_STATE, 32'h1FF, RESP_OKAY);
    // edge sense, falling polarity: a rise must pass unseen
    wr(OFS_OVERRIDE, 32'h8000_01FF, RESP_OKAY);
    flags(9'h000, 9'h000);
    wr(OFS_OVERRIDE, 32'h8000_0000, RESP_OKAY);
    flags(9'h1FF, 9'h1FF);
    clr();
    flags(9'h000, 9'h000);
    wr(OFS_EDGE_POL, 32'h1FF, RESP_OKAY);
    rd(OFS_EDGE_POL, 32'h1FF, RESP_OKAY);
    wr(OFS_OVERRIDE, 32'h8000_01FF, RESP_OKAY);
    flags(9'h1FF, 9'h1FF);
    clr();
    // level sense, low polarity, input high: rising setting must not matter
    wr(OFS_SENSE, 32'h1FF, RESP_OKAY);
    flags(9'h000, 9'h000);
    wr(OFS_LEVEL_POL, 32'h1FF, RESP_OKAY);
    flags(9'h1FF, 9'h1FF);
    clr();
    flags(9'h1FF, 9'h1FF);
    // override bit off: test bits ignored, pads low
    wr(OFS_OVERRIDE, 32'h0000_01FF, RESP_OKAY);
    clr();
    flags(9'h000, 9'h000);
    // override on with zeros, pads high: pads ignored
    wr(OFS_OVERRIDE, 32'h8000_0000, RESP_OKAY);
    @(posedge clk) pad_cmd <= 9'h1FF;
    clr();
    flags(9'h000, 9'h000);
    wr(OFS_OVERRIDE, 32'h0, RESP_OKAY);
    flags(9'h1FF, 9'h1FF);
    // glitch filter: short pulse removed only when filtering
    @(posedge clk) pad_cmd <= 9'h000;
    repeat (10) @(posedge clk);
    clr();
    flags(9'h000, 9'h000);
    wr(OFS_FILT, 32'h1FF, RESP_OKAY);
    pulse();
    flags(9'h000, 9'h000);
    wr(OFS_FILT, 32'h0, RESP_OKAY);
    pulse();
    flags(9'h1FF, 9'h1FF);
    // sampled capture still detects a held level
    wr(OFS_CAPTURE, 32'h0, RESP_OKAY);
    clr();
    flags(9'h000, 9'h000);
    @(posedge clk) pad_cmd <= 9'h1FF;
    flags(9'h1FF, 9'h1FF);
    // disable one line, zero writes leave state alone
    wr(OFS_LINE_CLR, 32'h001, RESP_OKAY);
    wr(OFS_LINE_SET, 32'h000, RESP_OKAY);
    rd(OFS_LINE_STATE, 32'h1FE, RESP_OKAY);
    clr();
    flags(9'h1FE, 9'h1FE);
    wr(OFS_MASK_CLR, 32'h002, RESP_OKAY);
    rd(OFS_MASK_STATE, 32'h1FD, RESP_OKAY);
    flags(9'h1FE, 9'h1FC);
    print_verdict();
  end

  // hang guard, far beyond the thousand or so cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end
endmodule
